// ---- cem_defs.svh ----
// Purpose: Constants for the core exception model block
// Assumes: Included by cem_pkg and the top module
// Notes:   Offsets are register indices on the plain software port
`ifndef CEM_DEFS_SVH
`define CEM_DEFS_SVH
// Core register indices
`define CEM_IDX_SP          4'hD
`define CEM_IDX_LINK        4'hE
`define CEM_IDX_PC          4'hF
`define CEM_PC_READ_ADD     32'h00000004
// Control register offsets (8-bit address, bit 7 selects control space)
`define CEM_OFF_CORE_BASE   8'h00
`define CEM_OFF_INTERRUPT_CONTROL_STATE_REG        8'h80
`define CEM_OFF_APP_INTERRUPT_RESET_CTRL       8'h81
`define CEM_OFF_CONTROL     8'h82
`define CEM_OFF_IRQ_ENABLE  8'h83
`define CEM_OFF_IRQ_PEND    8'h84
`define CEM_OFF_IRQ_CLRPEND 8'h85
`define CEM_OFF_SYS_PRI     8'h86
`define CEM_OFF_IRQ_PRI_LO  8'h88
`define CEM_OFF_PC          8'h90
`define CEM_OFF_DEBUG       8'h91
// Field positions
`define CEM_INTERRUPT_CONTROL_STATE_REG_VECT_HI    8
`define CEM_INTERRUPT_CONTROL_STATE_REG_NMI_SET    31
`define CEM_INTERRUPT_CONTROL_STATE_REG_DSC_SET    28
`define CEM_INTERRUPT_CONTROL_STATE_REG_DSC_CLR    27
`define CEM_INTERRUPT_CONTROL_STATE_REG_TICK_SET   26
`define CEM_INTERRUPT_CONTROL_STATE_REG_TICK_CLR   25
`define CEM_APP_INTERRUPT_RESET_CTRL_SYSRESET  2
`define CEM_CONTROL_STACK_SELECT   1
// Exception numbers
`define CEM_EXC_NONE        9'h000
`define CEM_EXC_RESET       9'h001
`define CEM_EXC_NMI         9'h002
`define CEM_EXC_FAULT       9'h003
`define CEM_EXC_SVC         9'h00B
`define CEM_EXC_DSC         9'h00E
`define CEM_EXC_TICK        9'h00F
`define CEM_EXC_IRQ0        9'h010
// Priorities, encoded as value+3 so -3..3 maps to 0..6; idle is 7
`define CEM_PRI_RESET       3'h0
`define CEM_PRI_NMI         3'h1
`define CEM_PRI_FAULT       3'h2
`define CEM_PRI_CFG_BASE    3'h3
`define CEM_PRI_IDLE        3'h7
// Reset values
`define CEM_RST_WORD        32'h00000000
`define CEM_NUM_IRQ         32
`endif

// ---- cem_pkg.sv ----
// Purpose: Types for the core exception model block
// Assumes: cem_defs.svh holds all numbers
// Notes:   Types only
`include "cem_defs.svh"
package cem_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cem_bus_type;
  typedef struct packed {
    logic       valid;
    logic [8:0] number;
    logic [2:0] pri;
  } cem_cand_type;
  typedef enum logic [1:0] {
    CEM_ST_THREAD  = 2'b01,
    CEM_ST_HANDLER = 2'b10
  } cem_state_type;
endpackage : cem_pkg

// ---- cem_core.sv ----
// Purpose: Core register file, banked stack pointers and exception sources
// Assumes: Single clock, synchronous inputs, one-cycle read latency port
// Notes:   Picks the winning pending exception and tracks the active one
`timescale 1ns/100ps
`default_nettype none
`include "cem_defs.svh"
// Contract
// - Reading index 13 gives process stack if stack select set, else main.
// - Thirteen general registers, two stack pointers, link and PC held.
// - Power-on reset clears processor, control space and debug logic.
// - Local reset clears processor and control space, keeps debug state.
// - Reset-selected fields take reset values when reset is released.
// - Reset always enabled at fixed priority minus three.
// - Non-maskable interrupt always enabled, priority minus two, beats all but reset.
// - Non-maskable pends by hardware signal or software set bit.
// - Generic fault always enabled at fixed priority minus one.
// - Every detected fault reports through the one generic fault.
// - Supervisor call instruction raises always-enabled, configurable-priority exception.
// - Two system interrupts and 32 external lines, each configurable priority.
// - Deferred call always enabled, pended or cleared only by its bits.
// - Tick set and clear bits always work for software.
// - Software disables external interrupts and sets or clears any pending.
// - Hardware pends any interrupt except the deferred call.
// - No fault cause status bits exist.
// - Fixed exception numbers; external N is sixteen plus N.
// - Active vector number sits in bits 8:0 of control state register.
// - System reset request sits at bit 2 of reset control register.
// - Equal priority resolves to lowest exception number; lower value wins.
// - Configurable priorities are two bits, below the fixed ones.
// - Only strictly higher priority preempts an active exception.
module cem_core
  import cem_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_local_rst,
  input  wire cem_bus_type i_bus,
  input  wire logic        i_nmi,
  input  wire logic        i_fault,
  input  wire logic        i_svc_exec,
  input  wire logic        i_tick_event,
  input  wire logic [31:0] i_irq,
  input  wire logic        i_exc_return,
  output logic      [31:0] o_rdata,
  output logic      [8:0]  o_active_vector,
  output logic      [8:0]  o_take_number,
  output logic             o_take,
  output logic             o_sys_reset_req
);

  // Any reset level reinitialises the processor and control space
  logic any_rst;
  assign any_rst = i_rst | i_local_rst;

  logic [31:0] gpr_q [0:12];
  logic [31:0] psp_q, msp_q, link_q, pc_q;
  logic [31:0] dbg_q;
  logic        stack_select_q;
  logic        nmi_pend_q, fault_pend_q, svc_pend_q, dsc_pend_q, tick_pend_q;
  logic [31:0] irq_en_q, irq_pend_q;
  logic [1:0]  svc_pri_q, dsc_pri_q, tick_pri_q;
  logic [63:0] irq_pri_q;
  cem_state_type st_q;
  logic [8:0]  active_q;
  logic [2:0]  active_pri_q;

  logic wr_interrupt_control_state_reg, wr_ctl, wr_core;
  assign wr_interrupt_control_state_reg = i_bus.wr && i_bus.addr == `CEM_OFF_INTERRUPT_CONTROL_STATE_REG;
  assign wr_ctl  = i_bus.wr && i_bus.addr == `CEM_OFF_CONTROL;
  assign wr_core = i_bus.wr && i_bus.addr[7:4] == 4'h0;

  // Map a two-bit configurable level below the fixed levels
  function automatic logic [2:0] cfg_pri(input logic [1:0] f);
    cfg_pri = `CEM_PRI_CFG_BASE + {1'b0, f};
  endfunction : cfg_pri

  // Read a core register by index
  function automatic logic [31:0] core_read(input logic [3:0] n);
    if (n == `CEM_IDX_PC)
      core_read = pc_q + `CEM_PC_READ_ADD;
    else if (n == `CEM_IDX_LINK)
      core_read = link_q;
    else if (n == `CEM_IDX_SP)
      core_read = stack_select_q ? psp_q : msp_q;
    else
      core_read = gpr_q[n];
  endfunction : core_read

  // General registers, stack pointers and link
  always_ff @(posedge i_clock) begin
    if (any_rst) begin
      for (int k = 0; k < 13; k++) gpr_q[k] <= `CEM_RST_WORD;
      psp_q  <= `CEM_RST_WORD;
      msp_q  <= `CEM_RST_WORD;
      link_q <= `CEM_RST_WORD;
    end else if (wr_core) begin
      if (i_bus.addr[3:0] == `CEM_IDX_LINK)
        link_q <= i_bus.wdata;
      else if (i_bus.addr[3:0] == `CEM_IDX_SP) begin
        // Only the selected bank moves; the other is untouched
        if (stack_select_q) psp_q <= {i_bus.wdata[31:2], 2'b00};
        else         msp_q <= {i_bus.wdata[31:2], 2'b00};
      end else if (i_bus.addr[3:0] != `CEM_IDX_PC)
        gpr_q[i_bus.addr[3:0]] <= i_bus.wdata;
    end
  end

  // Program counter written through its own offset
  always_ff @(posedge i_clock) begin
    if (any_rst)
      pc_q <= `CEM_RST_WORD;
    else if (i_bus.wr && i_bus.addr == `CEM_OFF_PC)
      pc_q <= i_bus.wdata;
  end

  // Debug scratch survives a local reset, cleared only at power-on
  always_ff @(posedge i_clock) begin
    if (i_rst)
      dbg_q <= `CEM_RST_WORD;
    else if (i_bus.wr && i_bus.addr == `CEM_OFF_DEBUG)
      dbg_q <= i_bus.wdata;
  end

  // Stack select: writes ignored in handler mode
  always_ff @(posedge i_clock) begin
    if (any_rst)
      stack_select_q <= 1'b0;
    else if (wr_ctl && st_q == CEM_ST_THREAD)
      stack_select_q <= i_bus.wdata[`CEM_CONTROL_STACK_SELECT];
  end

  // Software-configured priorities; cleared by any reset
  always_ff @(posedge i_clock) begin
    if (any_rst) begin
      svc_pri_q  <= 2'h0;
      dsc_pri_q  <= 2'h0;
      tick_pri_q <= 2'h0;
      irq_pri_q  <= 64'h0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `CEM_OFF_SYS_PRI) begin
        svc_pri_q  <= i_bus.wdata[1:0];
        dsc_pri_q  <= i_bus.wdata[3:2];
        tick_pri_q <= i_bus.wdata[5:4];
      end
      if (i_bus.addr == `CEM_OFF_IRQ_PRI_LO)
        irq_pri_q[31:0] <= i_bus.wdata;
      if (i_bus.addr == `CEM_OFF_IRQ_PRI_LO + 8'h01)
        irq_pri_q[63:32] <= i_bus.wdata;
    end
  end

  // External enable mask
  always_ff @(posedge i_clock) begin
    if (any_rst)
      irq_en_q <= 32'h0;
    else if (i_bus.wr && i_bus.addr == `CEM_OFF_IRQ_ENABLE)
      irq_en_q <= i_bus.wdata;
  end

  // Winner of the arbitration, computed below
  cem_cand_type win;
  logic         take;

  // Pending state of fixed and system exceptions; set wins over clear
  always_ff @(posedge i_clock) begin
    if (any_rst) begin
      nmi_pend_q   <= 1'b0;
      fault_pend_q <= 1'b0;
      svc_pend_q   <= 1'b0;
      dsc_pend_q   <= 1'b0;
      tick_pend_q  <= 1'b0;
    end else begin
      nmi_pend_q <= i_nmi | (wr_interrupt_control_state_reg & i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_NMI_SET])
                  | (nmi_pend_q & ~(take && win.number == `CEM_EXC_NMI));
      // All fault kinds funnel into one pending bit, no cause kept
      fault_pend_q <= i_fault | (fault_pend_q & ~(take && win.number == `CEM_EXC_FAULT));
      svc_pend_q <= i_svc_exec | (svc_pend_q & ~(take && win.number == `CEM_EXC_SVC));
      // No hardware input reaches the deferred call
      dsc_pend_q <= (wr_interrupt_control_state_reg & i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_DSC_SET])
                  | (dsc_pend_q & ~(wr_interrupt_control_state_reg & i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_DSC_CLR])
                     & ~(take && win.number == `CEM_EXC_DSC));
      tick_pend_q <= i_tick_event | (wr_interrupt_control_state_reg & i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_TICK_SET])
                   | (tick_pend_q & ~(wr_interrupt_control_state_reg & i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_TICK_CLR])
                      & ~(take && win.number == `CEM_EXC_TICK));
    end
  end

  // External pending: hardware and software set, software clears
  always_ff @(posedge i_clock) begin
    if (any_rst)
      irq_pend_q <= 32'h0;
    else
      for (int k = 0; k < `CEM_NUM_IRQ; k++) begin
        irq_pend_q[k] <= i_irq[k]
          | (i_bus.wr && i_bus.addr == `CEM_OFF_IRQ_PEND && i_bus.wdata[k])
          | (irq_pend_q[k]
             & ~(i_bus.wr && i_bus.addr == `CEM_OFF_IRQ_CLRPEND && i_bus.wdata[k])
             & ~(take && win.number == `CEM_EXC_IRQ0 + 9'(k)));
      end
  end

  // Arbitration walks in ascending number so ties keep the lowest
  always_comb begin
    win = '{valid: 1'b0, number: `CEM_EXC_NONE, pri: `CEM_PRI_IDLE};
    if (nmi_pend_q)
      win = '{valid: 1'b1, number: `CEM_EXC_NMI, pri: `CEM_PRI_NMI};
    if (fault_pend_q && `CEM_PRI_FAULT < win.pri)
      win = '{valid: 1'b1, number: `CEM_EXC_FAULT, pri: `CEM_PRI_FAULT};
    if (svc_pend_q && cfg_pri(svc_pri_q) < win.pri)
      win = '{valid: 1'b1, number: `CEM_EXC_SVC, pri: cfg_pri(svc_pri_q)};
    if (dsc_pend_q && cfg_pri(dsc_pri_q) < win.pri)
      win = '{valid: 1'b1, number: `CEM_EXC_DSC, pri: cfg_pri(dsc_pri_q)};
    if (tick_pend_q && cfg_pri(tick_pri_q) < win.pri)
      win = '{valid: 1'b1, number: `CEM_EXC_TICK, pri: cfg_pri(tick_pri_q)};
    for (int k = 0; k < `CEM_NUM_IRQ; k++)
      if (irq_pend_q[k] && irq_en_q[k] && cfg_pri(irq_pri_q[2*k +: 2]) < win.pri)
        win = '{valid: 1'b1, number: `CEM_EXC_IRQ0 + 9'(k),
                pri: cfg_pri(irq_pri_q[2*k +: 2])};
  end

  // Strict compare: an equal level waits for the active handler
  assign take = win.valid && win.pri < active_pri_q;

  // Thread/handler state and active exception; a preemption overwrites the active one, no nesting kept
  always_ff @(posedge i_clock) begin
    if (any_rst) begin
      st_q         <= CEM_ST_THREAD;
      active_q     <= `CEM_EXC_NONE;
      active_pri_q <= `CEM_PRI_IDLE;
    end else begin
      unique case (st_q)
        CEM_ST_THREAD: begin
          if (take) begin
            st_q         <= CEM_ST_HANDLER;
            active_q     <= win.number;
            active_pri_q <= win.pri;
          end
        end
        CEM_ST_HANDLER: begin
          if (take) begin
            active_q     <= win.number;
            active_pri_q <= win.pri;
          end else if (i_exc_return) begin
            // Return drops to thread; nested context is software's job
            st_q         <= CEM_ST_THREAD;
            active_q     <= `CEM_EXC_NONE;
            active_pri_q <= `CEM_PRI_IDLE;
          end
        end
      endcase
    end
  end

  // Take pulse and number registered straight to outputs
  always_ff @(posedge i_clock) begin
    if (any_rst) begin
      o_take        <= 1'b0;
      o_take_number <= `CEM_EXC_NONE;
    end else begin
      o_take        <= take;
      o_take_number <= win.number;
    end
  end

  assign o_active_vector = active_q;

  // System reset request pulses on a write of its bit
  always_ff @(posedge i_clock) begin
    if (any_rst)
      o_sys_reset_req <= 1'b0;
    else
      o_sys_reset_req <= i_bus.wr && i_bus.addr == `CEM_OFF_APP_INTERRUPT_RESET_CTRL
                         && i_bus.wdata[`CEM_APP_INTERRUPT_RESET_CTRL_SYSRESET];
  end

  // Read data one cycle after the strobe, zero on unmapped addresses
  always_ff @(posedge i_clock) begin
    if (any_rst)
      o_rdata <= `CEM_RST_WORD;
    else if (!i_bus.rd)
      o_rdata <= `CEM_RST_WORD;
    else if (i_bus.addr[7:4] == 4'h0)
      o_rdata <= core_read(i_bus.addr[3:0]);
    else
      unique case (i_bus.addr)
        `CEM_OFF_INTERRUPT_CONTROL_STATE_REG: o_rdata <= {nmi_pend_q, 2'b00, dsc_pend_q, 1'b0, tick_pend_q,
                                   17'h0, active_q};
        `CEM_OFF_CONTROL:    o_rdata <= {30'h0, stack_select_q, 1'b0};
        `CEM_OFF_IRQ_ENABLE: o_rdata <= irq_en_q;
        `CEM_OFF_IRQ_PEND:   o_rdata <= irq_pend_q;
        `CEM_OFF_SYS_PRI:    o_rdata <= {26'h0, tick_pri_q, dsc_pri_q, svc_pri_q};
        `CEM_OFF_IRQ_PRI_LO: o_rdata <= irq_pri_q[31:0];
        `CEM_OFF_PC:         o_rdata <= pc_q;
        `CEM_OFF_DEBUG:      o_rdata <= dbg_q;
        default:             o_rdata <= `CEM_RST_WORD;
      endcase
  end

  // Assertions
  // Named steps: a stack write lands in one bank only, by current select
  sequence sp_wr_main_s;
    wr_core && i_bus.addr[3:0] == `CEM_IDX_SP && !stack_select_q;
  endsequence
  sequence sp_wr_proc_s;
    wr_core && i_bus.addr[3:0] == `CEM_IDX_SP && stack_select_q;
  endsequence
  // A handler that is neither returning nor preempted keeps its place
  sequence handler_stay_s;
    st_q == CEM_ST_HANDLER && !i_exc_return;
  endsequence

  sp_select_read_a: assert property (@(posedge i_clock) disable iff (any_rst)
    i_bus.rd && i_bus.addr == 8'h0D |=> o_rdata == ($past(stack_select_q) ? $past(psp_q) : $past(msp_q)))
    else $error("stack read picks wrong bank");
  sp_write_align_a: assert property (@(posedge i_clock) disable iff (any_rst)
    sp_wr_main_s |=> msp_q == {$past(i_bus.wdata[31:2]), 2'b00} && $stable(psp_q))
    else $error("stack write wrong");
  pc_read_plus_a: assert property (@(posedge i_clock) disable iff (any_rst)
    i_bus.rd && i_bus.addr == 8'h0F |=> o_rdata == $past(pc_q) + 32'h4)
    else $error("pc read not plus four");
  debug_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_local_rst |=> $stable(dbg_q))
    else $error("local reset touched debug");
  nmi_pend_a: assert property (@(posedge i_clock) disable iff (any_rst)
    i_nmi |=> nmi_pend_q)
    else $error("nmi not pending");
  nmi_first_a: assert property (@(posedge i_clock) disable iff (any_rst)
    nmi_pend_q |-> win.number == `CEM_EXC_NMI)
    else $error("nmi lost arbitration");
  dsc_soft_only_a: assert property (@(posedge i_clock) disable iff (any_rst)
    !dsc_pend_q && !wr_interrupt_control_state_reg |=> !dsc_pend_q)
    else $error("deferred call pended by hardware");
  preempt_strict_a: assert property (@(posedge i_clock) disable iff (any_rst)
    handler_stay_s |=> active_q == $past(active_q) || active_pri_q < $past(active_pri_q))
    else $error("equal priority preempted");
  sys_reset_bit_a: assert property (@(posedge i_clock) disable iff (any_rst)
    o_sys_reset_req |-> $past(i_bus.wdata[2]) && $past(i_bus.addr) == `CEM_OFF_APP_INTERRUPT_RESET_CTRL)
    else $error("reset request without bit 2");
  active_vec_a: assert property (@(posedge i_clock) disable iff (any_rst)
    take |=> o_active_vector == $past(win.number))
    else $error("active vector wrong");
  psp_align_a: assert property (@(posedge i_clock) disable iff (any_rst)
    sp_wr_proc_s |=> psp_q == {$past(i_bus.wdata[31:2]), 2'b00} && $stable(msp_q))
    else $error("process stack write wrong");

  // Reset outranks everything; no setting can keep an exception alive
  reset_wins_a: assert property (@(posedge i_clock)
    any_rst |=> !o_take && o_active_vector == `CEM_EXC_NONE && st_q == CEM_ST_THREAD)
    else $error("reset did not override exceptions");

  // Fault, supervisor call and the tick set bit reach their pending bits one edge later; the deferred call clear bit drops it
  fault_pend_a: assert property (@(posedge i_clock) disable iff (any_rst)
    i_fault |=> fault_pend_q)
    else $error("fault not pending");
  svc_pend_a: assert property (@(posedge i_clock) disable iff (any_rst)
    i_svc_exec |=> svc_pend_q)
    else $error("supervisor call not pending");
  tick_set_a: assert property (@(posedge i_clock) disable iff (any_rst)
    wr_interrupt_control_state_reg && i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_TICK_SET] |=> tick_pend_q)
    else $error("tick set bit ignored");
  dsc_clear_a: assert property (@(posedge i_clock) disable iff (any_rst)
    wr_interrupt_control_state_reg && i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_DSC_CLR] && !i_bus.wdata[`CEM_INTERRUPT_CONTROL_STATE_REG_DSC_SET]
    |=> !dsc_pend_q)
    else $error("deferred call clear ignored");

  // Arbitration outcomes: masked lines wait, levels and numbers stay legal
  irq_masked_a: assert property (@(posedge i_clock) disable iff (any_rst)
    take && win.number >= `CEM_EXC_IRQ0 |-> irq_en_q[win.number[4:0]])
    else $error("disabled line was taken");
  cfg_level_a: assert property (@(posedge i_clock) disable iff (any_rst)
    take && win.number >= `CEM_EXC_SVC |-> win.pri >= `CEM_PRI_CFG_BASE)
    else $error("configurable level above fixed ones");
  exc_number_a: assert property (@(posedge i_clock) disable iff (any_rst)
    o_take |-> o_take_number inside {`CEM_EXC_NMI, `CEM_EXC_FAULT, `CEM_EXC_SVC,
      `CEM_EXC_DSC, `CEM_EXC_TICK} || (o_take_number >= `CEM_EXC_IRQ0 && o_take_number < 9'h030))
    else $error("taken number is reserved");

endmodule : cem_core
`default_nettype wire

// ---- cem_far_end.sv ----
// Purpose: Far-side model of the interrupt and fault sources of the core
// Assumes: Requests change just after a rising edge and last one cycle
// Notes:   Has no deferred call line, only software may pend that one
`timescale 1ns/100ps
`default_nettype none
module cem_far_end (
  input  wire logic        i_clock,
  output logic             o_nmi,
  output logic             o_fault,
  output logic             o_tick_event,
  output logic      [31:0] o_irq
);
  // Lines idle low
  initial begin
    o_nmi        = 1'b0;
    o_fault      = 1'b0;
    o_tick_event = 1'b0;
    o_irq        = 32'h00000000;
  end

  // One-cycle request: 0 nmi, 1 fault, 2 tick, 3+n external line n
  // A level held longer would re-pend after the take, so pulses only
  task automatic pulse(input int which);
    @(posedge i_clock);
    if (which == 0) o_nmi <= 1'b1;
    else if (which == 1) o_fault <= 1'b1;
    else if (which == 2) o_tick_event <= 1'b1;
    else o_irq[which-3] <= 1'b1;
    @(posedge i_clock);
    o_nmi        <= 1'b0;
    o_fault      <= 1'b0;
    o_tick_event <= 1'b0;
    o_irq        <= 32'h00000000;
  endtask : pulse
endmodule : cem_far_end
`default_nettype wire

// ---- core_exception_model_tb.sv ----
// Purpose: Self-checking bench for the core exception block
// Assumes: Read data one cycle after the read strobe, takes within ten cycles
// Notes:   Expected winners of the mixed-priority test come from a queue model; later takes expect fixed numbers
`timescale 1ns/100ps
`default_nettype none
module core_exception_model_tb
  import cem_pkg::*;
;
  logic        clock;
  logic        rst;
  logic        local_rst;
  cem_bus_type bus;
  logic        svc_go;
  logic        exc_ret;
  logic        nmi;
  logic        fault;
  logic        tick;
  logic [31:0] irq;
  logic [31:0] rdata;
  logic [8:0]  act_vec;
  logic [8:0]  take_num;
  logic        take;
  logic        sysreq;
  int          err_total;
  int          comparisons;
  logic [31:0] gr[16];
  int          pend_q[$];
  int          pri_of[int];
  int          e;

  cem_core dut_u (
    .i_clock(clock), .i_rst(rst), .i_local_rst(local_rst), .i_bus(bus),
    .i_nmi(nmi), .i_fault(fault), .i_svc_exec(svc_go), .i_tick_event(tick),
    .i_irq(irq), .i_exc_return(exc_ret), .o_rdata(rdata),
    .o_active_vector(act_vec), .o_take_number(take_num), .o_take(take),
    .o_sys_reset_req(sysreq)
  );
  cem_far_end far_u (
    .i_clock(clock), .o_nmi(nmi), .o_fault(fault), .o_tick_event(tick), .o_irq(irq)
  );

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    bus <= '0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus <= '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(rdata, exp, "read data");
  endtask : rd

  // One-cycle strobe: 0 supervisor call, 1 exception return, 2 local reset
  task automatic strobe(input int which);
    @(posedge clock);
    if (which == 0) svc_go <= 1'b1;
    else if (which == 1) exc_ret <= 1'b1;
    else local_rst <= 1'b1;
    @(posedge clock);
    svc_go    <= 1'b0;
    exc_ret   <= 1'b0;
    local_rst <= 1'b0;
  endtask : strobe

  task automatic take_chk(input int exp);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (take !== 1'b1 && k < 10);
    chk({31'h0, take}, 32'h00000001, "take seen");
    chk({23'h0, take_num}, exp[31:0], "take number");
    chk({23'h0, act_vec}, exp[31:0], "active vector");
  endtask : take_chk

  task automatic no_take(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk({31'h0, take}, 32'h00000000, "unexpected take");
    end
  endtask : no_take

  // Winner: lowest priority value, ties to the lowest number
  function automatic int pick();
    int best;
    best = pend_q[0];
    foreach (pend_q[i]) begin
      if (pri_of[pend_q[i]] < pri_of[best] ||
          (pri_of[pend_q[i]] == pri_of[best] && pend_q[i] < best)) best = pend_q[i];
    end
    return best;
  endfunction : pick

  task automatic close_out();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Watchdog at 20000 clock periods, far beyond the expected run
  initial begin
    #(5 * 20000);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    local_rst = 1'b0;
    bus = '0;
    svc_go = 1'b0;
    exc_ret = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    void'($urandom(32'h5597B4DE));
    rd(8'h80, 32'h00000000);
    rd(8'h91, 32'h00000000);
    for (int i = 0; i < 13; i++) begin
      gr[i] = $urandom;
      wr(i[7:0], gr[i]);
    end
    for (int i = 0; i < 13; i++) rd(i[7:0], gr[i]);
    gr[13] = $urandom;
    gr[14] = $urandom;
    wr(8'h0D, gr[13] | 32'h00000003);
    wr(8'h82, 32'h00000002);
    wr(8'h0D, gr[14] | 32'h00000001);
    rd(8'h0D, gr[14] & 32'hFFFFFFFC);
    wr(8'h82, 32'h00000000);
    rd(8'h0D, gr[13] & 32'hFFFFFFFC);
    gr[15] = $urandom;
    wr(8'h0E, gr[15]);
    rd(8'h0E, gr[15]);
    wr(8'h90, gr[14]);
    wr(8'h0F, gr[13]);
    rd(8'h0F, gr[14] + 32'h00000004);
    rd(8'h40, 32'h00000000);
    // Mixed priorities and an equal-priority tie pended in one write
    pri_of[16] = 3;
    pri_of[17] = 1;
    pri_of[19] = 0;
    pri_of[21] = 0;
    pend_q = {16, 17, 19, 21};
    wr(8'h83, 32'hFFFFFFFF);
    wr(8'h88, 32'h00000007);
    wr(8'h84, 32'h0000002B);
    repeat (4) begin
      e = pick();
      take_chk(e);
      no_take(3);
      for (int i = pend_q.size() - 1; i >= 0; i--) if (pend_q[i] == e) pend_q.delete(i);
      strobe(1);
    end
    // Hardware line, then the non-maskable interrupt preempts it
    far_u.pulse(3 + 7);
    take_chk(23);
    far_u.pulse(0);
    take_chk(2);
    strobe(1);
    // Disabled line stays pending until software clears it
    wr(8'h83, 32'h00000000);
    far_u.pulse(3 + 9);
    no_take(4);
    rd(8'h84, 32'h00000200);
    wr(8'h85, 32'h00000200);
    rd(8'h84, 32'h00000000);
    // Software pend and clear of the system interrupts under an active NMI, then each system source taken alone and the reset request
    wr(8'h80, 32'h80000000);
    take_chk(2);
    wr(8'h80, 32'h14000000);
    rd(8'h80, 32'h14000002);
    wr(8'h80, 32'h0A000000);
    rd(8'h80, 32'h00000002);
    strobe(1);
    no_take(4);
    wr(8'h80, 32'h10000000);
    take_chk(14);
    strobe(1);
    wr(8'h80, 32'h04000000);
    take_chk(15);
    strobe(1);
    far_u.pulse(1);
    take_chk(3);
    strobe(1);
    strobe(0);
    take_chk(11);
    strobe(1);
    far_u.pulse(2);
    take_chk(15);
    strobe(1);
    wr(8'h81, 32'h00000004);
    @(posedge clock);
    #1;
    chk({31'h0, sysreq}, 32'h00000000, "reset request one cycle");
    // Local reset keeps the debug word, power-on reset clears it
    wr(8'h91, gr[15]);
    strobe(2);
    rd(8'h91, gr[15]);
    rd(8'h00, 32'h00000000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h91, 32'h00000000);
    close_out();
  end

  // Reset request must pulse right after its write
  initial begin
    @(negedge rst);
    wait (bus.wr === 1'b1 && bus.addr === 8'h81);
    @(posedge clock);
    #1;
    chk({31'h0, sysreq}, 32'h00000001, "reset request");
  end
endmodule : core_exception_model_tb
`default_nettype wire
